// file: design/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  localparam int          DATA_W = 16;
  localparam int          ADDR_W = 4;

  // register offsets
  localparam logic [3:0]  OFS_CONTROL_ONE_LOW  = 4'h0;
  localparam logic [3:0]  OFS_CONTROL_ONE_HIGH = 4'h1;
  localparam logic [3:0]  OFS_CONTROL_TWO_LOW  = 4'h2;
  localparam logic [3:0]  OFS_SOURCE_DIVIDER   = 4'h3;
  localparam logic [3:0]  OFS_IRQ_STATUS       = 4'h4;
  localparam logic [3:0]  OFS_IRQ_MASK         = 4'h5;
  localparam logic [3:0]  OFS_RESULT           = 4'h6;

  // implemented bits per register
  localparam logic [15:0] CONTROL_ONE_LOW_BITS  = 16'ha000;
  localparam logic [15:0] CONTROL_ONE_HIGH_BITS = 16'h00e0;
  localparam logic [15:0] CONTROL_TWO_LOW_BITS  = 16'hdf7f;
  localparam logic [15:0] SOURCE_DIVIDER_BITS   = 16'h003f;
  localparam logic [15:0] IRQ_BITS              = 16'h000f;

  // reset values
  localparam logic [15:0] CONTROL_ONE_LOW_RESET  = 16'h0000;
  localparam logic [15:0] CONTROL_ONE_HIGH_RESET = 16'h0060;
  localparam logic [15:0] CONTROL_TWO_LOW_RESET  = 16'h0000;
  localparam logic [15:0] SOURCE_DIVIDER_RESET   = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET         = 16'h0000;

  // field positions
  localparam int          ENABLE_POS      = 15;
  localparam int          IDLE_STOP_POS   = 13;
  localparam int          FRACTIONAL_POS  = 7;
  localparam int          RESOLUTION_LSB  = 5;
  localparam int          REF_READY_IE_POS = 15;
  localparam int          REF_ERROR_IE_POS = 14;
  localparam int          EARLY_IE_POS    = 12;
  localparam int          EXT_REQUEST_POS = 11;
  localparam int          EARLY_TIME_LSB  = 8;
  localparam int          CORE_DIV_LSB    = 0;
  localparam int          SOURCE_DIV_LSB  = 0;
  localparam int          REF_READY_FLAG_POS = 15;

  // sticky status bit positions
  localparam int          ST_REF_READY = 0;
  localparam int          ST_REF_ERROR = 1;
  localparam int          ST_DONE      = 2;
  localparam int          ST_EARLY     = 3;

  // resolution codes
  localparam logic [1:0]  RES_12 = 2'h3;
  localparam logic [1:0]  RES_10 = 2'h2;
  localparam logic [1:0]  RES_8  = 2'h1;
  localparam logic [1:0]  RES_6  = 2'h0;

  // timing counts in core clock periods and source periods
  localparam logic [7:0]  CORE_DIV_MIN   = 8'h02;
  localparam logic [4:0]  CONV_OVERHEAD  = 5'h02;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef enum logic [0:0] {CONV_IDLE, CONV_RUN} conv_state_t;

endpackage : adc_ctrl_pkg

// file: design/adc_shared_core_control.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
// Function
// - module runs only while the enable bit is one
// - idle-stop bit halts the converter while the device idles
// - fractional-select picks left-justified fractional or right-justified integer results
// - resolution field picks 12/10/8/6 bits, resets to 12-bit
// - reference-ready enable lets band gap ready raise the common interrupt
// - reference-error enable lets band gap error raise the common interrupt
// - early enable moves channel interrupt from result ready to early flag
// - external request enable gates conversion requests from the trigger sequencer
// - early flag fires timing field plus one core periods before ready
// - core period is twice divider value in source periods, minimum two
// - unimplemented bits read zero and ignore writes
// - source clock is module clock divided by one to sixty-four
// - error flag sets when band gap drops while enabled; ready flag follows it
module adc_shared_core_control
  import adc_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire reg_req_t    req,
  output logic [15:0]      rdata,
  input  wire logic        idle_mode,
  input  wire logic        bandgap_ok,
  input  wire logic        ext_request,
  input  wire logic [11:0] sample_data,
  output logic [15:0]      result_data,
  output logic             result_valid,
  output logic             early_pulse,
  output logic             channel_irq,
  output logic             core_tick,
  output logic             module_active,
  output logic             irq
);

  logic [15:0]  control_one_low;
  logic [15:0]  control_one_high;
  logic [15:0]  control_two_low;
  logic [15:0]  source_divider;
  logic [3:0]   irq_status;
  logic [3:0]   irq_mask;
  logic [3:0]   next_irq_status;
  logic [3:0]   irq_events;
  logic [3:0]   irq_gate;
  logic         module_enable_bit;
  logic         idle_stop_bit;
  logic         fractional_select;
  logic [1:0]   shared_resolution_field;
  logic         reference_ready_irq_enable;
  logic         reference_error_irq_enable;
  logic         early_irq_enable;
  logic         external_request_enable;
  logic [2:0]   early_irq_timing_field;
  logic [6:0]   shared_core_divider;
  logic [5:0]   source_div_field;
  logic         active;
  logic [5:0]   source_cnt;
  logic         source_tick;
  logic [7:0]   core_div;
  logic [7:0]   core_cnt;
  conv_state_t  state;
  logic [4:0]   remaining;
  logic [4:0]   conv_len;
  logic [11:0]  held_sample;
  logic         accept;
  logic         early_hit;
  logic         done_hit;
  logic         bandgap_q;
  logic         ready_rise;
  logic         error_event;
  logic         wr_cfg;

  assign module_enable_bit          = control_one_low[ENABLE_POS];
  assign idle_stop_bit              = control_one_low[IDLE_STOP_POS];
  assign fractional_select          = control_one_high[FRACTIONAL_POS];
  assign shared_resolution_field    = control_one_high[RESOLUTION_LSB +: 2];
  assign reference_ready_irq_enable = control_two_low[REF_READY_IE_POS];
  assign reference_error_irq_enable = control_two_low[REF_ERROR_IE_POS];
  assign early_irq_enable           = control_two_low[EARLY_IE_POS];
  assign external_request_enable    = control_two_low[EXT_REQUEST_POS];
  assign early_irq_timing_field     = control_two_low[EARLY_TIME_LSB +: 3];
  assign shared_core_divider        = control_two_low[CORE_DIV_LSB +: 7];
  assign source_div_field           = source_divider[SOURCE_DIV_LSB +: 6];

  // configuration may be written at any time; software keeps it still while enabled
  assign wr_cfg = req.write;

  // register writes, unimplemented bits masked away
  always_ff @(posedge clk) begin
    if (reset) begin
      control_one_low  <= CONTROL_ONE_LOW_RESET;
      control_one_high <= CONTROL_ONE_HIGH_RESET;
      control_two_low  <= CONTROL_TWO_LOW_RESET;
      source_divider   <= SOURCE_DIVIDER_RESET;
      irq_mask         <= IRQ_MASK_RESET[3:0];
    end else if (wr_cfg) begin
      case (req.addr)
        OFS_CONTROL_ONE_LOW:  control_one_low  <= req.wdata & CONTROL_ONE_LOW_BITS;
        OFS_CONTROL_ONE_HIGH: control_one_high <= req.wdata & CONTROL_ONE_HIGH_BITS;
        OFS_CONTROL_TWO_LOW:  control_two_low  <= req.wdata & CONTROL_TWO_LOW_BITS;
        OFS_SOURCE_DIVIDER:   source_divider   <= req.wdata & SOURCE_DIVIDER_BITS;
        OFS_IRQ_MASK:         irq_mask         <= req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // read data, one cycle after the strobe and zero otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (req.read) begin
      case (req.addr)
        OFS_CONTROL_ONE_LOW:  rdata <= control_one_low;
        OFS_CONTROL_ONE_HIGH: rdata <= control_one_high;
        OFS_CONTROL_TWO_LOW:  rdata <= control_two_low;
        OFS_SOURCE_DIVIDER:   rdata <= source_divider;
        OFS_IRQ_STATUS:       rdata <= {bandgap_ok, 11'h000, irq_status};
        OFS_IRQ_MASK:         rdata <= {12'h000, irq_mask};
        OFS_RESULT:           rdata <= result_data;
        default:              rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // enable and idle stop
  assign active        = module_enable_bit && !(idle_stop_bit && idle_mode);
  assign module_active = active;

  // module clock divided by field plus one gives the source clock
  assign source_tick = active && (source_cnt == source_div_field);

  always_ff @(posedge clk) begin
    if (reset || !active) begin
      source_cnt <= 6'h00;
    end else if (source_tick) begin
      source_cnt <= 6'h00;
    end else begin
      source_cnt <= source_cnt + 6'h01;
    end
  end

  // core period is twice the divider in source periods, never below two
  assign core_div  = (shared_core_divider < 7'h02) ? CORE_DIV_MIN : {shared_core_divider, 1'b0};
  assign core_tick = source_tick && (core_cnt == core_div - 8'h01);

  always_ff @(posedge clk) begin
    if (reset || !active) begin
      core_cnt <= 8'h00;
    end else if (core_tick) begin
      core_cnt <= 8'h00;
    end else if (source_tick) begin
      core_cnt <= core_cnt + 8'h01;
    end
  end

  // conversion length grows with resolution
  always_comb begin
    case (shared_resolution_field)
      RES_12:  conv_len = 5'd12 + CONV_OVERHEAD;
      RES_10:  conv_len = 5'd10 + CONV_OVERHEAD;
      RES_8:   conv_len = 5'd8 + CONV_OVERHEAD;
      default: conv_len = 5'd6 + CONV_OVERHEAD;
    endcase
  end

  assign accept    = (state == CONV_IDLE) && active && external_request_enable && ext_request;
  assign early_hit = (state == CONV_RUN) && core_tick
                     && (remaining == ({2'b00, early_irq_timing_field} + 5'd2));
  assign done_hit  = (state == CONV_RUN) && core_tick && (remaining == 5'd1);

  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= CONV_IDLE;
      remaining   <= 5'd0;
      held_sample <= 12'h000;
    end else begin
      case (state)
        CONV_IDLE: begin
          if (accept) begin
            state       <= CONV_RUN;
            remaining   <= conv_len;
            held_sample <= sample_data;
          end
        end
        CONV_RUN: begin
          if (!active) begin
            state <= CONV_IDLE;
          end else if (done_hit) begin
            state     <= CONV_IDLE;
            remaining <= 5'd0;
          end else if (core_tick) begin
            remaining <= remaining - 5'd1;
          end
        end
        default: state <= CONV_IDLE;
      endcase
    end
  end

  // result formatting
  always_ff @(posedge clk) begin
    if (reset) begin
      result_data  <= 16'h0000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= done_hit;
      if (done_hit) begin
        if (fractional_select) begin
          case (shared_resolution_field)
            RES_12:  result_data <= {held_sample, 4'h0};
            RES_10:  result_data <= {held_sample[11:2], 6'h00};
            RES_8:   result_data <= {held_sample[11:4], 8'h00};
            default: result_data <= {held_sample[11:6], 10'h000};
          endcase
        end else begin
          case (shared_resolution_field)
            RES_12:  result_data <= {4'h0, held_sample};
            RES_10:  result_data <= {6'h00, held_sample[11:2]};
            RES_8:   result_data <= {8'h00, held_sample[11:4]};
            default: result_data <= {10'h000, held_sample[11:6]};
          endcase
        end
      end
    end
  end

  // channel interrupt source select
  always_ff @(posedge clk) begin
    if (reset) begin
      early_pulse <= 1'b0;
      channel_irq <= 1'b0;
    end else begin
      early_pulse <= early_hit;
      channel_irq <= early_irq_enable ? early_hit : done_hit;
    end
  end

  // band gap watch
  always_ff @(posedge clk) begin
    if (reset) begin
      bandgap_q <= 1'b0;
    end else begin
      bandgap_q <= bandgap_ok;
    end
  end

  assign ready_rise  = bandgap_ok && !bandgap_q;
  assign error_event = module_enable_bit && bandgap_q && !bandgap_ok;

  // sticky status, write one to clear, a new event wins over the clear
  assign irq_events = {early_hit, done_hit, error_event, ready_rise};

  always_comb begin
    next_irq_status = irq_status;
    if (req.write && (req.addr == OFS_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~req.wdata[3:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status <= 4'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign irq_gate = {1'b1, 1'b1, reference_error_irq_enable, reference_ready_irq_enable};
  assign irq      = |(irq_status & irq_mask & irq_gate);

  // ---- assertion helpers
  logic [15:0] period_cnt;
  logic        tick_seen;
  logic [3:0]  ticks_after_early;
  logic        early_seen;
  logic [15:0] expect_period;

  assign expect_period = ({10'h000, source_div_field} + 16'h0001) * {8'h00, core_div};

  always_ff @(posedge clk) begin
    if (reset || !active) begin
      period_cnt <= 16'h0000;
      tick_seen  <= 1'b0;
    end else if (core_tick) begin
      period_cnt <= 16'h0000;
      tick_seen  <= 1'b1;
    end else begin
      period_cnt <= period_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state == CONV_IDLE) begin
      ticks_after_early <= 4'h0;
      early_seen        <= 1'b0;
    end else if (early_hit) begin
      ticks_after_early <= 4'h0;
      early_seen        <= 1'b1;
    end else if (core_tick) begin
      ticks_after_early <= ticks_after_early + 4'h1;
    end
  end

  sequence s_request_refused;
    ext_request && !external_request_enable && state == CONV_IDLE;
  endsequence

  sequence s_still_idle;
    state == CONV_IDLE;
  endsequence

  a_disabled_no_tick: assert property (@(posedge clk) disable iff (reset)
    !module_enable_bit |-> !core_tick && !module_active)
    else $error("core clock ran while module disabled");

  a_idle_stop_halts: assert property (@(posedge clk) disable iff (reset)
    (idle_stop_bit && idle_mode) |=> (state == CONV_IDLE) && !core_tick)
    else $error("converter kept running in idle with stop bit set");

  a_request_gated: assert property (@(posedge clk) disable iff (reset)
    s_request_refused |=> s_still_idle)
    else $error("request accepted while external requests disabled");

  a_core_period: assert property (@(posedge clk) disable iff (reset)
    (core_tick && tick_seen && $stable(control_two_low) && $stable(source_divider))
      |-> period_cnt == expect_period - 16'h0001)
    else $error("core clock period wrong");

  a_early_lead: assert property (@(posedge clk) disable iff (reset)
    (done_hit && early_seen) |-> ticks_after_early == {1'b0, early_irq_timing_field})
    else $error("early flag lead time wrong");

  a_channel_source: assert property (@(posedge clk) disable iff (reset)
    (done_hit && !early_irq_enable) |=> channel_irq && result_valid)
    else $error("channel interrupt missing at result ready");

  a_common_irq: assert property (@(posedge clk) disable iff (reset)
    (irq_status[ST_REF_READY] && irq_mask[ST_REF_READY] && !reference_ready_irq_enable
      && irq_status[3:1] == 3'h0) |-> !irq)
    else $error("common interrupt raised by disabled ready source");

  a_error_sticky: assert property (@(posedge clk) disable iff (reset)
    error_event |=> irq_status[ST_REF_ERROR] ##0
      (irq == 1'b1 || !(irq_mask[ST_REF_ERROR] && reference_error_irq_enable)))
    else $error("reference error flag not set");

  a_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
    (req.read && req.addr == OFS_CONTROL_TWO_LOW) |=> (rdata & ~CONTROL_TWO_LOW_BITS) == 16'h0000)
    else $error("unimplemented bits read nonzero");

  a_format_frac: assert property (@(posedge clk) disable iff (reset)
    (done_hit && fractional_select && shared_resolution_field == RES_8) |=> result_data[7:0] == 8'h00)
    else $error("fractional result not left justified");

  a_reset_res: assert property (@(posedge clk)
    $fell(reset) |-> shared_resolution_field == RES_12)
    else $error("resolution field not twelve bit after reset");

endmodule : adc_shared_core_control

// file: verif/adc_shared_core_control_tb.sv
`timescale 1ns/1ns
module adc_shared_core_control_tb
  import adc_ctrl_pkg::*;
();
  logic        clk;
  logic        reset;
  reg_req_t    req;
  logic [15:0] rdata;
  logic        idle_mode;
  logic        bandgap_ok;
  logic        ext_request;
  logic [11:0] sample_data;
  logic [15:0] result_data;
  logic        result_valid;
  logic        early_pulse;
  logic        channel_irq;
  logic        core_tick;
  logic        module_active;
  logic        irq;
  int          n_fail;
  int          comparisons;
  int          te;
  int          tr;
  int          tc;
  int          base;
  logic [11:0] s;

  adc_shared_core_control uut (
    .clk          (clk),
    .reset        (reset),
    .req          (req),
    .rdata        (rdata),
    .idle_mode    (idle_mode),
    .bandgap_ok   (bandgap_ok),
    .ext_request  (ext_request),
    .sample_data  (sample_data),
    .result_data  (result_data),
    .result_valid (result_valid),
    .early_pulse  (early_pulse),
    .channel_irq  (channel_irq),
    .core_tick    (core_tick),
    .module_active(module_active),
    .irq          (irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rdchk

  // drive idle level, rewrite the enable register, then look at the active level
  task automatic act(input logic idle, input logic [15:0] c0, input logic e);
    @(posedge clk);
    idle_mode <= idle;
    wr(OFS_CONTROL_ONE_LOW, c0);
    @(negedge clk);
    chk({15'h0, module_active}, {15'h0, e});
  endtask : act

  // configuration always happens with the module switched off
  task automatic cfg(input logic [1:0] res, input logic fr, input logic eie, input logic [2:0] t, input logic ext);
    wr(OFS_CONTROL_ONE_LOW, 16'h0000);
    wr(OFS_CONTROL_ONE_HIGH, {8'h00, fr, res, 5'h00});
    wr(OFS_CONTROL_TWO_LOW, {3'h0, eie, ext, t, 8'h00});
    wr(OFS_CONTROL_ONE_LOW, 16'h8000);
  endtask : cfg

  task automatic per(input logic [6:0] d, input logic [5:0] sd, input logic [15:0] e);
    int n;
    int m;
    wr(OFS_CONTROL_ONE_LOW, 16'h0000);
    wr(OFS_CONTROL_TWO_LOW, {9'h000, d});
    wr(OFS_SOURCE_DIVIDER, {10'h000, sd});
    wr(OFS_CONTROL_ONE_LOW, 16'h8000);
    @(negedge clk);
    for (n = 0; n < 600 && core_tick !== 1'b1; n++) @(negedge clk);
    m = 0;
    do begin
      @(negedge clk);
      m++;
    end while (core_tick !== 1'b1 && m < 600);
    if (m >= 600) begin
      n_fail++;
      final_report();
    end
    chk(m[15:0], e);
  endtask : per

  // one request pulse; records cycles of early, channel and result pulses
  task automatic conv(input logic [11:0] smp, input logic must);
    int n;
    te = -1;
    tr = -1;
    tc = -1;
    @(posedge clk);
    ext_request <= 1'b1;
    sample_data <= smp;
    @(posedge clk);
    ext_request <= 1'b0;
    for (n = 1; n < 200 && tr < 0; n++) begin
      @(negedge clk);
      if (early_pulse === 1'b1) te = n;
      if (channel_irq === 1'b1) tc = n;
      if (result_valid === 1'b1) tr = n;
    end
    if (must && tr < 0) begin
      n_fail++;
      final_report();
    end
  endtask : conv

  initial begin
    #900000;
    n_fail++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    req = '0;
    idle_mode = 1'b0;
    bandgap_ok = 1'b0;
    ext_request = 1'b0;
    sample_data = 12'h000;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rdchk(OFS_CONTROL_ONE_LOW, CONTROL_ONE_LOW_RESET);
    rdchk(OFS_CONTROL_ONE_HIGH, CONTROL_ONE_HIGH_RESET);
    rdchk(OFS_CONTROL_TWO_LOW, CONTROL_TWO_LOW_RESET);
    rdchk(OFS_SOURCE_DIVIDER, SOURCE_DIVIDER_RESET);
    rdchk(OFS_IRQ_STATUS, 16'h0000);
    rdchk(OFS_IRQ_MASK, IRQ_MASK_RESET);
    rdchk(OFS_RESULT, 16'h0000);
    rdchk(4'h7, 16'h0000);
    // all-ones writes keep only implemented bits, enable stays clear
    wr(OFS_CONTROL_ONE_LOW, 16'h7fff);
    rdchk(OFS_CONTROL_ONE_LOW, 16'h2000);
    wr(OFS_CONTROL_ONE_HIGH, 16'hffff);
    rdchk(OFS_CONTROL_ONE_HIGH, CONTROL_ONE_HIGH_BITS);
    wr(OFS_CONTROL_TWO_LOW, 16'hffff);
    rdchk(OFS_CONTROL_TWO_LOW, CONTROL_TWO_LOW_BITS);
    wr(4'h7, 16'hffff);
    rdchk(4'h7, 16'h0000);
    wr(OFS_CONTROL_TWO_LOW, 16'h0000);
    act(1'b0, 16'h8000, 1'b1);
    act(1'b1, 16'h8000, 1'b1);
    act(1'b1, 16'ha000, 1'b0);
    act(1'b0, 16'ha000, 1'b1);
    act(1'b0, 16'h0000, 1'b0);
    per(7'h00, 6'h00, 16'd2);
    per(7'h01, 6'h00, 16'd2);
    per(7'h03, 6'h00, 16'd6);
    per(7'h7f, 6'h00, 16'd254);
    per(7'h02, 6'h01, 16'd8);
    per(7'h01, 6'h3f, 16'd128);
    wr(OFS_CONTROL_ONE_LOW, 16'h0000);
    wr(OFS_SOURCE_DIVIDER, 16'h0000);
    wr(OFS_CONTROL_TWO_LOW, 16'h0000);
    @(posedge clk);
    bandgap_ok <= 1'b1;
    rdchk(OFS_IRQ_STATUS, 16'h8001);
    wr(OFS_IRQ_MASK, 16'h0001);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr(OFS_CONTROL_TWO_LOW, 16'h8000);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    wr(OFS_IRQ_MASK, 16'h0000);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0001);
    wr(OFS_IRQ_STATUS, 16'h0001);
    rdchk(OFS_IRQ_STATUS, 16'h8000);
    chk({15'h0, irq}, 16'h0000);
    wr(OFS_CONTROL_TWO_LOW, 16'h4000);
    wr(OFS_IRQ_MASK, 16'h0003);
    wr(OFS_CONTROL_ONE_LOW, 16'h8000);
    @(posedge clk);
    bandgap_ok <= 1'b0;
    rdchk(OFS_IRQ_STATUS, 16'h0002);
    chk({15'h0, irq}, 16'h0001);
    // switch off before touching configuration; the error flag stays
    wr(OFS_CONTROL_ONE_LOW, 16'h0000);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    wr(OFS_CONTROL_TWO_LOW, 16'h0000);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    @(posedge clk);
    bandgap_ok <= 1'b1;
    wr(OFS_IRQ_STATUS, 16'h000f);
    rdchk(OFS_IRQ_STATUS, 16'h8000);
    cfg(RES_12, 1'b0, 1'b0, 3'h0, 1'b0);
    conv(12'h123, 1'b0);
    chk({15'h0, tr < 0}, 16'h0001);
    for (int t = 0; t < 8; t++) begin
      s = 12'h9a0 + 12'(t);
      cfg(RES_12, t[0], t[1], t[2:0], 1'b1);
      conv(s, 1'b1);
      chk(16'(tr - te), 16'((t + 1) * 2));
      chk(16'(tc), t[1] ? 16'(te) : 16'(tr));
      chk(result_data, t[0] ? {s, 4'h0} : {4'h0, s});
      rdchk(OFS_RESULT, t[0] ? {s, 4'h0} : {4'h0, s});
    end
    rdchk(OFS_IRQ_STATUS, 16'h800c);
    wr(OFS_IRQ_MASK, 16'h000c);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    wr(OFS_IRQ_STATUS, 16'h000c);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    // conversion length shrinks by one core period per dropped bit; early timing stays 000
    for (int r = 3; r >= 0; r--) begin
      cfg(2'(r), r[0], 1'b0, 3'h0, 1'b1);
      rdchk(OFS_CONTROL_ONE_HIGH, {8'h00, r[0], 2'(r), 5'h00});
      conv(12'h5a5, 1'b1);
      if (r == 3) base = tr;
      chk(16'(base - tr), 16'((6 - 2 * r) * 2));
      chk(result_data, r[0] ? 16'h5a50 & (16'hffff << (10 - 2 * r)) : 16'h05a5 >> (6 - 2 * r));
    end
    final_report();
  end
endmodule : adc_shared_core_control_tb
